// >>> hw/ubf_top.sv
// Summary of operation
// - transmit write while queue is full sets the tx overflow flag
// - receive read while queue is empty sets the rx underflow flag
// - pending rx data (at least three bytes when to_three is set) and four quiet frames set the idle time-out flag
// - time-out irq bit is flag and enable together
// - three irq enables reset to zero and gate the three irq bits
// - writing a clear bit drops its flag; clear bit self-resets next cycle
// - bit rate is clock over ratio times divider plus one plus eighths
// - oversample ratio resets to sixteen; software keeps it six to sixteen
// - integer divider sixteen bits and fractional divider three bits, reset zero
// - delay bit moves the receive sample one clock later
// - earlier bit moves the receive sample one clock sooner when the integer divider is one or more; at zero a sample comes only on a fractional carry
// - tx queue pops are counted; reaching threshold gives a batch event
// - rx queue pushes are counted; reaching threshold gives a batch event
// - tx queue level, full and empty are readable
// - rx queue level, full and empty are readable
// - frame time is start, data, optional parity and stop bits
// - soft clear zeroes both queue pointers and contents
`timescale 1ns/10ps
`default_nettype none
`include "ubf_defines.svh"
module ubf_top (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic [31:0] awaddr_i,
    input wire logic awvalid_i,
    output logic awready_o,
    input wire logic [31:0] wdata_i,
    input wire logic [3:0] wstrb_i,
    input wire logic wvalid_i,
    output logic wready_o,
    output logic [1:0] bresp_o,
    output logic bvalid_o,
    input wire logic bready_i,
    input wire logic [31:0] araddr_i,
    input wire logic arvalid_i,
    output logic arready_o,
    output logic [31:0] rdata_o,
    output logic [1:0] rresp_o,
    output logic rvalid_o,
    input wire logic rready_i,
    output logic irq_o,
    input wire logic tx_wr_i,
    input wire logic [7:0] tx_wdata_i,
    input wire logic tx_pop_i,
    output logic [7:0] tx_data_o,
    output logic tx_empty_o,
    input wire logic rx_push_i,
    input wire logic [7:0] rx_wdata_i,
    input wire logic rx_rd_i,
    output logic [7:0] rx_data_o,
    input wire logic [1:0] word_size_i,
    input wire logic parity_en_i,
    input wire logic two_stop_i,
    input wire logic tx_batch_clear_i,
    input wire logic rx_batch_clear_i,
    output logic tx_batch_done_o,
    output logic rx_batch_done_o,
    output logic os_tick_o,
    output logic bit_tick_o,
    output logic sample_o
);
    ubf_pkg::ubf_regs_s q, d;
    logic [7:0] tx_head, rx_head;
    logic [4:0] tx_level, rx_level;
    logic tx_full, tx_empty, rx_full, rx_empty;
    logic tx_push, tx_pop, rx_push, rx_pop;
    logic ovf_set, unf_set, to_set, pend;
    logic [31:0] wm, nw;
    logic [4:0] thr_n;

    function automatic logic [31:0] strb_mask(input logic [3:0] s);
        return {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                          input logic [31:0] m);
        return (o & ~m) | (n & m);
    endfunction

    // four frame times counted in bit ticks; two_stop_i gives two stop bits, else one
    function automatic logic [5:0] tout_limit(input logic [1:0] sz, input logic par,
                                              input logic two);
        logic [5:0] f;
        f = 6'h06 + {4'h0, sz} + {5'h00, par} + (two ? 6'h02 : 6'h01);
        return 6'(f * `UBF_TO_FRAMES);
    endfunction

    function automatic logic [31:0] ext_img(input ubf_pkg::ubf_regs_s s);
        return (32'(s.flags & s.ena) << `UBF_IRQ_POS)
             | (32'(s.flags) << `UBF_FLAG_POS)
             | (32'(s.ena) << `UBF_ENA_POS);
    endfunction

    function automatic logic [31:0] rate_img(input ubf_pkg::ubf_regs_s s);
        return (32'(s.retard) << `UBF_RETARD_POS)
             | (32'(s.advance) << `UBF_ADVANCE_POS)
             | (32'(s.oversample_ratio) << `UBF_OSR_POS)
             | (32'(s.idiv) << `UBF_IDIV_POS)
             | (32'(s.fractional_rate_divider) << `UBF_FRACTIONAL_RATE_DIVIDER_POS);
    endfunction

    function automatic logic [31:0] thr_img(input ubf_pkg::ubf_regs_s s);
        return (32'(s.tx_thr) << `UBF_TXTHR_POS) | (32'(s.rx_thr) << `UBF_RXTHR_POS);
    endfunction

    assign tx_push = tx_wr_i && !tx_full;
    assign tx_pop = tx_pop_i && !tx_empty;
    assign rx_push = rx_push_i && !rx_full;
    assign rx_pop = rx_rd_i && !rx_empty;
    assign ovf_set = tx_wr_i && tx_full;
    assign unf_set = rx_rd_i && rx_empty;
    assign thr_n = q.to_three ? 5'h03 : 5'h01;
    assign pend = rx_level >= thr_n;
    assign wm = strb_mask(q.w_strb);

    always_comb begin
        d = q;
        nw = 32'h0000_0000;
        to_set = 1'b0;
        if (awvalid_i && q.awready) begin
            d.aw_have = 1'b1;
            d.aw_addr = awaddr_i;
        end
        if (wvalid_i && q.wready) begin
            d.w_have = 1'b1;
            d.w_data = wdata_i;
            d.w_strb = wstrb_i;
        end
        if (q.bvalid && bready_i) begin
            d.bvalid = 1'b0;
        end
        if (q.rvalid && rready_i) begin
            d.rvalid = 1'b0;
        end
        d.clr = 3'h0;
        d.soft_clr = 1'b0;
        if (q.aw_have && q.w_have && !q.bvalid) begin
            d.aw_have = 1'b0;
            d.w_have = 1'b0;
            d.bvalid = 1'b1;
            d.bresp = `UBF_RESP_OKAY;
            case (q.aw_addr)
                `UBF_EXT_IRQ_ADDR: begin
                    nw = merge(ext_img(q), q.w_data, wm);
                    d.ena = nw[`UBF_ENA_POS +: 3];
                    d.clr = 3'((q.w_data & wm) >> `UBF_CLR_POS);
                end
                `UBF_BIT_RATE_ADDR: begin
                    nw = merge(rate_img(q), q.w_data, wm);
                    d.retard = nw[`UBF_RETARD_POS];
                    d.advance = nw[`UBF_ADVANCE_POS];
                    d.oversample_ratio = nw[`UBF_OSR_POS +: 5];
                    d.idiv = nw[`UBF_IDIV_POS +: 16];
                    d.fractional_rate_divider = nw[`UBF_FRACTIONAL_RATE_DIVIDER_POS +: 3];
                end
                `UBF_QUEUE_ADDR: begin
                    nw = merge(thr_img(q), q.w_data, wm);
                    d.tx_thr = nw[`UBF_TXTHR_POS +: 5];
                    d.rx_thr = nw[`UBF_RXTHR_POS +: 5];
                end
                `UBF_CTRL_ADDR: begin
                    nw = merge(32'(q.to_three) << `UBF_TO3_POS, q.w_data, wm);
                    d.soft_clr = q.w_data[`UBF_SOFTCLR_POS] & wm[`UBF_SOFTCLR_POS];
                    d.to_three = nw[`UBF_TO3_POS];
                end
                default: begin
                    d.bresp = `UBF_RESP_SLVERR;
                end
            endcase
        end
        if (arvalid_i && q.arready) begin
            d.rvalid = 1'b1;
            d.rresp = `UBF_RESP_OKAY;
            case (araddr_i)
                `UBF_EXT_IRQ_ADDR: begin
                    d.rdata = ext_img(q);
                end
                `UBF_BIT_RATE_ADDR: begin
                    d.rdata = rate_img(q);
                end
                `UBF_QUEUE_ADDR: begin
                    d.rdata = thr_img(q)
                            | (32'(tx_level) << `UBF_TXLVL_POS)
                            | (32'(tx_full) << `UBF_TX_QUEUE_FULL_POS)
                            | (32'(tx_empty) << `UBF_TX_QUEUE_EMPTY_POS)
                            | (32'(rx_level) << `UBF_RXLVL_POS)
                            | (32'(rx_full) << `UBF_RX_QUEUE_FULL_POS)
                            | (32'(rx_empty) << `UBF_RX_QUEUE_EMPTY_POS);
                end
                `UBF_CTRL_ADDR: begin
                    d.rdata = 32'(q.to_three) << `UBF_TO3_POS;
                end
                default: begin
                    d.rdata = 32'h0000_0000;
                    d.rresp = `UBF_RESP_SLVERR;
                end
            endcase
        end
        d.awready = !d.aw_have && !d.bvalid;
        d.wready = !d.w_have && !d.bvalid;
        d.arready = !d.rvalid;
        // idle time-out fires once per quiet period
        case (q.to_st)
            ubf_pkg::UBF_TO_IDLE: begin
                d.to_cnt = 6'h00;
                if (pend) begin
                    d.to_st = ubf_pkg::UBF_TO_COUNT;
                end
            end
            ubf_pkg::UBF_TO_COUNT: begin
                if (rx_push_i) begin
                    d.to_cnt = 6'h00;
                end else if (!pend) begin
                    d.to_st = ubf_pkg::UBF_TO_IDLE;
                end else if (bit_tick_o) begin
                    if (q.to_cnt + 6'h01 >= tout_limit(word_size_i, parity_en_i, two_stop_i)) begin
                        d.to_st = ubf_pkg::UBF_TO_FIRED;
                        to_set = 1'b1;
                    end else begin
                        d.to_cnt = q.to_cnt + 6'h01;
                    end
                end
            end
            ubf_pkg::UBF_TO_FIRED: begin
                d.to_cnt = 6'h00;
                if (rx_push_i) begin
                    d.to_st = ubf_pkg::UBF_TO_COUNT;
                end else if (!pend) begin
                    d.to_st = ubf_pkg::UBF_TO_IDLE;
                end
            end
            default: begin
                d.to_st = ubf_pkg::UBF_TO_IDLE;
            end
        endcase
        // set beats a clear landing in the same cycle
        d.flags = (q.flags & ~q.clr) | {ovf_set, unf_set, to_set};
        d.irq = |(q.flags & q.ena);
        d.tx_done = 1'b0;
        if (tx_batch_clear_i) begin
            d.tx_cnt = 5'h00;
        end else if (tx_pop) begin
            if (q.tx_cnt + 5'h01 >= q.tx_thr) begin
                d.tx_cnt = 5'h00;
                d.tx_done = 1'b1;
            end else begin
                d.tx_cnt = q.tx_cnt + 5'h01;
            end
        end
        d.rx_done = 1'b0;
        if (rx_batch_clear_i) begin
            d.rx_cnt = 5'h00;
        end else if (rx_push) begin
            if (q.rx_cnt + 5'h01 >= q.rx_thr) begin
                d.rx_cnt = 5'h00;
                d.rx_done = 1'b1;
            end else begin
                d.rx_cnt = q.rx_cnt + 5'h01;
            end
        end
        if (tx_pop) begin
            d.tx_data = tx_head;
        end
        if (rx_pop) begin
            d.rx_data = rx_head;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            q <= '0;
            q.oversample_ratio <= `UBF_OSR_RST;
            q.tx_thr <= `UBF_THR_RST;
            q.rx_thr <= `UBF_THR_RST;
            q.to_st <= ubf_pkg::UBF_TO_IDLE;
        end else begin
            q <= d;
        end
    end

    ubf_fifo u_tx_fifo (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .clear_i(q.soft_clr),
        .push_i(tx_push),
        .push_data_i(tx_wdata_i),
        .pop_i(tx_pop_i),
        .pop_data_o(tx_head),
        .level_o(tx_level),
        .full_o(tx_full),
        .empty_o(tx_empty)
    );

    ubf_fifo u_rx_fifo (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .clear_i(q.soft_clr),
        .push_i(rx_push_i),
        .push_data_i(rx_wdata_i),
        .pop_i(rx_rd_i),
        .pop_data_o(rx_head),
        .level_o(rx_level),
        .full_o(rx_full),
        .empty_o(rx_empty)
    );

    // ratio outside six to sixteen is left to software
    ubf_baud u_baud (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .osr_i(q.oversample_ratio),
        .idiv_i(q.idiv),
        .fractional_rate_divider_i(q.fractional_rate_divider),
        .retard_i(q.retard),
        .advance_i(q.advance),
        .os_tick_o(os_tick_o),
        .bit_tick_o(bit_tick_o),
        .sample_o(sample_o)
    );

    assign awready_o = q.awready;
    assign wready_o = q.wready;
    assign bvalid_o = q.bvalid;
    assign bresp_o = q.bresp;
    assign arready_o = q.arready;
    assign rvalid_o = q.rvalid;
    assign rdata_o = q.rdata;
    assign rresp_o = q.rresp;
    assign irq_o = q.irq;
    assign tx_data_o = q.tx_data;
    assign tx_empty_o = tx_empty;
    assign rx_data_o = q.rx_data;
    assign tx_batch_done_o = q.tx_done;
    assign rx_batch_done_o = q.rx_done;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    chk_ovf_set: assert property (tx_wr_i && tx_full |=> q.flags[2])
        else $error("tx overflow flag not set");
    chk_unf_set: assert property (rx_rd_i && rx_empty |=> q.flags[1])
        else $error("rx underflow flag not set");
    chk_tout_pend: assert property ($rose(q.flags[0]) |-> $past(pend))
        else $error("time-out without pending data");
    chk_irq_gate: assert property ((q.flags & q.ena) != 3'h0 |=> irq_o)
        else $error("unmasked flag did not raise irq");
    chk_irq_quiet: assert property ((q.flags & q.ena) == 3'h0 |=> !irq_o)
        else $error("irq high with no unmasked flag");
    chk_clear_drop: assert property (q.clr[1] && !unf_set |=> !q.flags[1])
        else $error("clear did not drop flag");
    chk_flag_sticky: assert property (q.flags[2] && !q.clr[2] |=> q.flags[2])
        else $error("flag dropped without clear");
    chk_tx_batch: assert property (tx_pop && !tx_batch_clear_i
        && q.tx_cnt + 5'h01 == q.tx_thr |=> tx_batch_done_o && q.tx_cnt == 5'h00)
        else $error("tx batch event missing");
    chk_rx_batch: assert property (rx_push && !rx_batch_clear_i
        && q.rx_cnt + 5'h01 == q.rx_thr |=> rx_batch_done_o)
        else $error("rx batch event missing");
    chk_soft_clear: assert property (q.soft_clr |=> tx_level == 5'h00 && rx_empty)
        else $error("soft clear left data");
endmodule
`default_nettype wire

// >>> hw/ubf_defines.svh
`ifndef UBF_DEFINES_SVH
`define UBF_DEFINES_SVH
`define UBF_EXT_IRQ_ADDR 32'h5001_5410
`define UBF_BIT_RATE_ADDR 32'h5001_5414
`define UBF_QUEUE_ADDR 32'h5001_5418
`define UBF_CTRL_ADDR 32'h5001_541C
`define UBF_IRQ_POS 24
`define UBF_FLAG_POS 16
`define UBF_CLR_POS 8
`define UBF_ENA_POS 0
`define UBF_RETARD_POS 30
`define UBF_ADVANCE_POS 29
`define UBF_OSR_POS 24
`define UBF_IDIV_POS 3
`define UBF_FRACTIONAL_RATE_DIVIDER_POS 0
`define UBF_TXTHR_POS 24
`define UBF_RXTHR_POS 16
`define UBF_TXLVL_POS 11
`define UBF_TX_QUEUE_FULL_POS 10
`define UBF_TX_QUEUE_EMPTY_POS 9
`define UBF_RXLVL_POS 3
`define UBF_RX_QUEUE_FULL_POS 2
`define UBF_RX_QUEUE_EMPTY_POS 1
`define UBF_SOFTCLR_POS 0
`define UBF_TO3_POS 1
`define UBF_OSR_RST 5'h10
`define UBF_THR_RST 5'h01
`define UBF_TO_FRAMES 6'h04
`define UBF_DEPTH 5'h10
`define UBF_RESP_OKAY 2'h0
`define UBF_RESP_SLVERR 2'h2
`endif

// >>> hw/ubf_pkg.sv
package ubf_pkg;
    typedef enum logic [1:0] {UBF_TO_IDLE, UBF_TO_COUNT, UBF_TO_FIRED} ubf_tout_e;
    typedef struct packed {
        logic [3:0] wr_ptr;
        logic [3:0] rd_ptr;
        logic [4:0] level;
        logic full;
        logic empty;
    } ubf_fifo_s;
    typedef struct packed {
        logic [16:0] cnt;
        logic [2:0] acc;
        logic [4:0] os_cnt;
        logic os_tk;
        logic bit_tk;
        logic smp;
        logic smp_dly;
    } ubf_baud_s;
    typedef struct packed {
        logic awready;
        logic wready;
        logic arready;
        logic aw_have;
        logic [31:0] aw_addr;
        logic w_have;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic [2:0] ena;
        logic [2:0] flags;
        logic [2:0] clr;
        logic irq;
        logic retard;
        logic advance;
        logic [4:0] oversample_ratio;
        logic [15:0] idiv;
        logic [2:0] fractional_rate_divider;
        logic [4:0] tx_thr;
        logic [4:0] rx_thr;
        logic [4:0] tx_cnt;
        logic [4:0] rx_cnt;
        logic tx_done;
        logic rx_done;
        logic soft_clr;
        logic to_three;
        ubf_tout_e to_st;
        logic [5:0] to_cnt;
        logic [7:0] tx_data;
        logic [7:0] rx_data;
    } ubf_regs_s;
endpackage

// >>> hw/ubf_fifo.sv
`timescale 1ns/10ps
`default_nettype none
`include "ubf_defines.svh"
module ubf_fifo (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic clear_i,
    input wire logic push_i,
    input wire logic [7:0] push_data_i,
    input wire logic pop_i,
    output logic [7:0] pop_data_o,
    output logic [4:0] level_o,
    output logic full_o,
    output logic empty_o
);
    ubf_pkg::ubf_fifo_s q, d;
    logic [7:0] mem [16];
    logic do_push, do_pop;
    assign do_push = push_i && !q.full;
    assign do_pop = pop_i && !q.empty;
    always_comb begin
        d = q;
        if (clear_i) begin
            d.wr_ptr = 4'h0;
            d.rd_ptr = 4'h0;
            d.level = 5'h00;
        end else begin
            d.wr_ptr = q.wr_ptr + 4'(do_push);
            d.rd_ptr = q.rd_ptr + 4'(do_pop);
            d.level = q.level + 5'(do_push) - 5'(do_pop);
        end
        d.full = d.level == `UBF_DEPTH;
        d.empty = d.level == 5'h00;
    end
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            q <= '0;
            q.empty <= 1'b1;
        end else begin
            q <= d;
        end
    end
    // clear zeroes contents too, so stale bytes never reappear
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            for (int i = 0; i < 16; i++) mem[i] <= 8'h00;
        end else if (clear_i) begin
            for (int i = 0; i < 16; i++) mem[i] <= 8'h00;
        end else if (do_push) begin
            mem[q.wr_ptr] <= push_data_i;
        end
    end
    assign pop_data_o = mem[q.rd_ptr];
    assign level_o = q.level;
    assign full_o = q.full;
    assign empty_o = q.empty;
    chk_fill_to_full: assert property (@(posedge clk_i) disable iff (!resetn_i)
        push_i && !pop_i && !clear_i && q.level == 5'h0F |=> full_o && level_o == 5'h10)
        else $error("fifo did not fill at sixteen");
endmodule
`default_nettype wire

// >>> hw/ubf_baud.sv
`timescale 1ns/10ps
`default_nettype none
module ubf_baud (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic [4:0] osr_i,
    input wire logic [15:0] idiv_i,
    input wire logic [2:0] fractional_rate_divider_i,
    input wire logic retard_i,
    input wire logic advance_i,
    output logic os_tick_o,
    output logic bit_tick_o,
    output logic sample_o
);
    ubf_pkg::ubf_baud_s q, d;
    logic wrap, norm, early;
    logic [3:0] sum;
    logic [4:0] mid;
    assign wrap = q.cnt == 17'h00000;
    assign sum = {1'b0, q.acc} + {1'b0, fractional_rate_divider_i};
    assign mid = osr_i >> 1;
    assign norm = wrap && q.os_cnt == mid;
    // advance needs a divider of two or more cycles, else no earlier cycle exists
    assign early = q.cnt == 17'h00001 && q.os_cnt == mid;
    always_comb begin
        d = q;
        d.os_tk = wrap;
        d.bit_tk = 1'b0;
        if (wrap) begin
            d.acc = sum[2:0];
            d.cnt = {1'b0, idiv_i} + 17'(sum[3]);
            if (q.os_cnt + 5'h01 >= osr_i) begin
                d.os_cnt = 5'h00;
                d.bit_tk = 1'b1;
            end else begin
                d.os_cnt = q.os_cnt + 5'h01;
            end
        end else begin
            d.cnt = q.cnt - 17'h00001;
        end
        d.smp_dly = norm;
        if (retard_i) begin
            d.smp = q.smp_dly;
        end else if (advance_i) begin
            d.smp = early;
        end else begin
            d.smp = norm;
        end
    end
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end
    assign os_tick_o = q.os_tk;
    assign bit_tick_o = q.bit_tk;
    assign sample_o = q.smp;
    chk_retard_shift: assert property (@(posedge clk_i) disable iff (!resetn_i)
        retard_i && norm ##1 retard_i |=> sample_o)
        else $error("retarded sample not one cycle late");
    chk_bit_on_os: assert property (@(posedge clk_i) disable iff (!resetn_i)
        bit_tick_o |-> os_tick_o)
        else $error("bit tick without oversample tick");
endmodule
`default_nettype wire

// >>> tb/ubf_peer.sv
`timescale 1ns/10ps
`default_nettype none
module ubf_peer (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic pop_req_i,
    input wire logic push_req_i,
    input wire logic [7:0] byte_i,
    output logic tx_pop_o,
    output logic rx_push_o,
    output logic [7:0] rx_wdata_o
);
    // data not held past a push: inverse shows any stale capture
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            tx_pop_o <= 1'b0;
            rx_push_o <= 1'b0;
            rx_wdata_o <= 8'h00;
        end else begin
            tx_pop_o <= pop_req_i;
            rx_push_o <= push_req_i;
            rx_wdata_o <= push_req_i ? byte_i : ~rx_wdata_o;
        end
    end
endmodule
`default_nettype wire

// >>> tb/testbench.sv
`timescale 1ns/10ps
`default_nettype none
`include "ubf_defines.svh"
module testbench;
    logic clk_i, resetn_i, awvalid_i, wvalid_i, bready_i, arvalid_i, rready_i, irq_o;
    logic [31:0] awaddr_i, wdata_i, araddr_i, rdata_o, d;
    logic [3:0] wstrb_i;
    logic awready_o, wready_o, bvalid_o, arready_o, rvalid_o, tx_wr_i, tx_pop_i, tx_empty_o;
    logic [1:0] bresp_o, rresp_o, word_size_i, r;
    logic [7:0] tx_wdata_i, tx_data_o, rx_wdata_i, rx_data_o, pbyte;
    logic rx_push_i, rx_rd_i, parity_en_i, two_stop_i, tx_batch_clear_i, rx_batch_clear_i;
    logic tx_batch_done_o, rx_batch_done_o, os_tick_o, bit_tick_o, sample_o, pop_req, push_req;
    int num_errors = 0, num_checks = 0, txb = 0, rxb = 0, n;
    typedef struct {logic [31:0] a; logic w; logic [31:0] v; logic [31:0] e; logic [1:0] rs;} ubf_row_s;
    ubf_row_s rows[9] = '{
        '{`UBF_EXT_IRQ_ADDR, 0, 0, 32'h0, 2'h0}, '{`UBF_BIT_RATE_ADDR, 0, 0, 32'h1000_0000, 2'h0},
        '{`UBF_QUEUE_ADDR, 0, 0, 32'h0101_0202, 2'h0},
        '{`UBF_BIT_RATE_ADDR, 1, 32'h6607_FFFF, 0, 2'h0},
        '{`UBF_BIT_RATE_ADDR, 0, 0, 32'h6607_FFFF, 2'h0},
        '{`UBF_BIT_RATE_ADDR, 1, 32'h1000_0000, 0, 2'h0},
        '{`UBF_EXT_IRQ_ADDR, 1, 32'h0707_0007, 0, 2'h0}, '{`UBF_EXT_IRQ_ADDR, 0, 0, 32'h7, 2'h0},
        '{32'h5001_5420, 0, 0, 32'h0, 2'h2}};
    ubf_top uut (.clk_i, .resetn_i, .awaddr_i, .awvalid_i, .awready_o, .wdata_i, .wstrb_i,
        .wvalid_i, .wready_o, .bresp_o, .bvalid_o, .bready_i, .araddr_i, .arvalid_i, .arready_o,
        .rdata_o, .rresp_o, .rvalid_o, .rready_i, .irq_o, .tx_wr_i, .tx_wdata_i, .tx_pop_i,
        .tx_data_o, .tx_empty_o, .rx_push_i, .rx_wdata_i, .rx_rd_i, .rx_data_o, .word_size_i,
        .parity_en_i, .two_stop_i, .tx_batch_clear_i, .rx_batch_clear_i, .tx_batch_done_o,
        .rx_batch_done_o, .os_tick_o, .bit_tick_o, .sample_o);
    ubf_peer peer (.clk_i, .resetn_i, .pop_req_i(pop_req), .push_req_i(push_req),
        .byte_i(pbyte), .tx_pop_o(tx_pop_i), .rx_push_o(rx_push_i), .rx_wdata_o(rx_wdata_i));
    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        if (tx_batch_done_o === 1'b1) txb++;
        if (rx_batch_done_o === 1'b1) rxb++;
    end
    task automatic chk(input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            num_errors++;
            $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] v);
        logic aw = 1'b0;
        logic w = 1'b0;
        @(posedge clk_i);
        awaddr_i <= a;
        wdata_i <= v;
        awvalid_i <= 1'b1;
        wvalid_i <= 1'b1;
        while (!(aw && w)) begin
            @(posedge clk_i);
            aw |= awvalid_i && awready_o;
            w |= wvalid_i && wready_o;
            awvalid_i <= awvalid_i && !aw;
            wvalid_i <= wvalid_i && !w;
        end
        bready_i <= 1'b1;
        do @(posedge clk_i); while (bvalid_o !== 1'b1);
        r = bresp_o;
        bready_i <= 1'b0;
    endtask
    task automatic rd(input logic [31:0] a);
        @(posedge clk_i);
        araddr_i <= a;
        arvalid_i <= 1'b1;
        do @(posedge clk_i); while (arready_o !== 1'b1);
        arvalid_i <= 1'b0;
        rready_i <= 1'b1;
        do @(posedge clk_i); while (rvalid_o !== 1'b1);
        d = rdata_o;
        r = rresp_o;
        rready_i <= 1'b0;
    endtask
    task automatic gap(output int m);
        @(posedge clk_i iff bit_tick_o === 1'b1);
        m = 0;
        do begin
            @(posedge clk_i);
            m++;
        end while (sample_o !== 1'b1);
    endtask
    task automatic results;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        resetn_i = 1'b0;
        {awvalid_i, wvalid_i, bready_i, arvalid_i, rready_i, tx_wr_i, rx_rd_i} = '0;
        {parity_en_i, two_stop_i, tx_batch_clear_i, rx_batch_clear_i, pop_req, push_req} = 6'h30;
        {awaddr_i, wdata_i, araddr_i, tx_wdata_i, pbyte} = '0;
        wstrb_i = 4'hF;
        word_size_i = 2'h3;
        repeat (3) @(posedge clk_i);
        resetn_i <= 1'b1;
        foreach (rows[i]) begin
            if (rows[i].w) wr(rows[i].a, rows[i].v);
            else rd(rows[i].a);
            if (!rows[i].w) chk(rows[i].e, d);
            chk({30'h0, rows[i].rs}, {30'h0, r});
        end
        $display("register table done");
        resetn_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        resetn_i <= 1'b1;
        rd(`UBF_BIT_RATE_ADDR);
        chk(32'h1000_0000, d);
        rd(`UBF_EXT_IRQ_ADDR);
        chk(32'h0, d);
        wr(`UBF_EXT_IRQ_ADDR, 32'h7);
        for (int i = 0; i < 17; i++) begin
            @(posedge clk_i);
            tx_wr_i <= 1'b1;
            tx_wdata_i <= 8'(i);
        end
        @(posedge clk_i);
        tx_wr_i <= 1'b0;
        rd(`UBF_QUEUE_ADDR);
        chk(32'h0101_8402, d);
        rd(`UBF_EXT_IRQ_ADDR);
        chk(32'h0404_0007, d);
        chk(32'h1, {31'h0, irq_o});
        wr(`UBF_EXT_IRQ_ADDR, 32'h0000_0407);
        rd(`UBF_EXT_IRQ_ADDR);
        chk(32'h7, d);
        chk(32'h0, {31'h0, irq_o});
        @(posedge clk_i);
        rx_rd_i <= 1'b1;
        @(posedge clk_i);
        rx_rd_i <= 1'b0;
        rd(`UBF_EXT_IRQ_ADDR);
        chk(32'h0202_0007, d);
        wr(`UBF_EXT_IRQ_ADDR, 32'h0000_0207);
        $display("overflow and underflow done");
        wr(`UBF_QUEUE_ADDR, 32'h0401_0000);
        txb = 0;
        @(posedge clk_i);
        pop_req <= 1'b1;
        repeat (4) @(posedge clk_i);
        pop_req <= 1'b0;
        repeat (4) @(posedge clk_i);
        chk(32'h1, txb);
        chk(32'h3, {24'h0, tx_data_o});
        // two ticks give the bit period at ratio 16, divider 0
        @(posedge clk_i iff bit_tick_o === 1'b1);
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (bit_tick_o !== 1'b1);
        chk(32'd16, n);
        gap(n);
        chk(32'd9, n);
        wr(`UBF_BIT_RATE_ADDR, 32'h5000_0000);
        gap(n);
        chk(32'd10, n);
        // earlier sample needs a divider of two cycles
        wr(`UBF_BIT_RATE_ADDR, 32'h3000_0008);
        gap(n);
        chk(32'd17, n);
        wr(`UBF_BIT_RATE_ADDR, 32'h1000_0000);
        $display("baud and sample window done");
        rxb = 0;
        pbyte <= 8'hA5;
        push_req <= 1'b1;
        @(posedge clk_i);
        push_req <= 1'b0;
        // parity and two stops give twelve-bit frames, so 48 quiet bits
        repeat (2) @(posedge clk_i);
        repeat (47) @(posedge clk_i iff bit_tick_o === 1'b1);
        rd(`UBF_EXT_IRQ_ADDR);
        chk(32'h7, d);
        @(posedge clk_i iff bit_tick_o === 1'b1);
        rd(`UBF_EXT_IRQ_ADDR);
        chk(32'h0101_0007, d);
        chk(32'h1, rxb);
        @(posedge clk_i);
        rx_rd_i <= 1'b1;
        @(posedge clk_i);
        rx_rd_i <= 1'b0;
        @(posedge clk_i);
        chk(32'hA5, {24'h0, rx_data_o});
        wr(`UBF_CTRL_ADDR, 32'h1);
        repeat (3) @(posedge clk_i);
        rd(`UBF_QUEUE_ADDR);
        chk(32'h0401_0202, d);
        $display("batch, time-out and soft clear done");
        results;
    end
    initial begin
        repeat (5000) @(posedge clk_i);
        num_errors++;
        results;
    end
endmodule
`default_nettype wire
